// file: rtl/pwp_defines.svh
// Constants of the peripheral write-protect block: offsets, layouts, resets.
// Assumes a 32-bit AXI4-Lite register bus and one clock.
// Summary of operation
// RL1: Writing zero to any protection bit leaves that peripheral's state unchanged.
// RL2: Writing one to a clear-register bit removes that peripheral's write protection.
// RL3: Each protection bit reads back: one protected, zero writes permitted.
// RL4: Group one: trace 6, usb 5, port 3, flash 2, debug 1; debug set.
// RL5: Group two: i2s 20, touch 19, dac 18, comparators 17, adc 16, timers 8-10, events 1.
// RL6: Writes to a protected peripheral are discarded and answered with an error.
// RL7: Double protect or double unprotect of a peripheral returns an error.
// RL8: Writing one to a set-register bit applies that peripheral's write protection.
`ifndef PWP_DEFINES_SVH
`define PWP_DEFINES_SVH

`define PWP_ADDR_W 6
`define PWP_G1_CLR_OFS 6'h00
`define PWP_G1_SET_OFS 6'h04
`define PWP_G2_CLR_OFS 6'h10
`define PWP_G2_SET_OFS 6'h14
`define PWP_IRQ_STAT_OFS 6'h20
`define PWP_IRQ_MASK_OFS 6'h24

`define PWP_BIT_TRACE_BUFFER 6
`define PWP_BIT_USB 5
`define PWP_BIT_PIN_PORT 3
`define PWP_BIT_FLASH_CONTROLLER 2
`define PWP_BIT_DEBUG_UNIT 1
`define PWP_BIT_I2S 20
`define PWP_BIT_TOUCH_CONTROLLER 19
`define PWP_BIT_DAC 18
`define PWP_BIT_COMPARATORS 17
`define PWP_BIT_ADC 16
`define PWP_BIT_CONTROL_TIMER_0 8
`define PWP_BIT_CONTROL_TIMER_1 9
`define PWP_BIT_CONTROL_TIMER_2 10
`define PWP_BIT_EVENT_ROUTER 1

`define PWP_G1_VALID ((32'h1 << `PWP_BIT_TRACE_BUFFER) | (32'h1 << `PWP_BIT_USB) | \
  (32'h1 << `PWP_BIT_PIN_PORT) | (32'h1 << `PWP_BIT_FLASH_CONTROLLER) | \
  (32'h1 << `PWP_BIT_DEBUG_UNIT))
`define PWP_G2_VALID ((32'h1 << `PWP_BIT_I2S) | (32'h1 << `PWP_BIT_TOUCH_CONTROLLER) | \
  (32'h1 << `PWP_BIT_DAC) | (32'h1 << `PWP_BIT_COMPARATORS) | (32'h1 << `PWP_BIT_ADC) | \
  (32'h1 << `PWP_BIT_CONTROL_TIMER_0) | (32'h1 << `PWP_BIT_CONTROL_TIMER_1) | \
  (32'h1 << `PWP_BIT_CONTROL_TIMER_2) | (32'h1 << `PWP_BIT_EVENT_ROUTER))
`define PWP_G1_RESET 32'h0000_0002
`define PWP_G2_RESET 32'h0080_0000

`define PWP_EV_DOUBLE 0
`define PWP_EV_BLOCKED 1
`define PWP_IRQ_VALID 32'h0000_0003

`define PWP_RESP_OKAY 2'h0
`define PWP_RESP_SLVERR 2'h2

`endif

// file: rtl/pwp_pkg.sv
// Types shared by the peripheral write-protect block.
// Assumes pwp_defines.svh for widths.
`include "pwp_defines.svh"
package pwp_pkg;
  // Write check from the peripheral bridge: which peripheral is targeted
  typedef struct packed {
    logic valid;
    logic group2;
    logic [4:0] index;
  } pwp_chk_s;
  typedef logic [31:0] pwp_word_t;
endpackage

// file: rtl/pwp_top.sv
// Peripheral write-protect registers for two bridge groups, AXI4-Lite slave.
// Assumes the bridge presents each peripheral write on the check port.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "pwp_defines.svh"
module pwp_top
  import pwp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`PWP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PWP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pwp_chk_s periph_chk,
  output logic periph_chk_done,
  output logic periph_chk_err,
  output pwp_word_t group1_protect,
  output pwp_word_t group2_protect,
  output logic irq
);
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [`PWP_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  pwp_word_t w_data_reg, w_data_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  pwp_word_t rdata_reg, rdata_next;
  pwp_word_t g1_reg, g1_next, g2_reg, g2_next;
  pwp_word_t stat_reg, stat_next, mask_reg, mask_next;
  logic irq_reg, irq_next, chk_done_reg, chk_done_next, chk_err_reg, chk_err_next;
  logic do_write, wr_double, wr_unmapped, chk_hit, aw_fire, w_fire, ar_fire;
  pwp_word_t wr_ones, stat_set, stat_clr;

  always_comb begin
    aw_fire = s_axi_awvalid && awready_reg;
    w_fire = s_axi_wvalid && wready_reg;
    ar_fire = s_axi_arvalid && arready_reg;
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    aw_addr_next = aw_fire ? s_axi_awaddr : aw_addr_reg;
    // Lanes without a strobe carry zero, a no-op for the clear, set and status registers but written as zero into the mask
    w_data_next = w_fire ? (s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}})
                         : w_data_reg;
    aw_held_next = do_write ? 1'b0 : (aw_held_reg || aw_fire);
    w_held_next = do_write ? 1'b0 : (w_held_reg || w_fire);
    awready_next = !aw_held_next;
    wready_next = !w_held_next;
    g1_next = g1_reg;
    g2_next = g2_reg;
    mask_next = mask_reg;
    stat_clr = 32'h0;
    stat_set = 32'h0;
    wr_ones = 32'h0;
    wr_double = 1'b0;
    wr_unmapped = 1'b0;
    if (do_write) begin
      case (aw_addr_reg)
        `PWP_G1_CLR_OFS: begin
          wr_ones = w_data_reg & `PWP_G1_VALID;
          wr_double = |(wr_ones & ~g1_reg); // [RL7]
          g1_next = g1_reg & ~wr_ones; // [RL1] [RL2]
        end
        `PWP_G1_SET_OFS: begin
          wr_ones = w_data_reg & `PWP_G1_VALID;
          wr_double = |(wr_ones & g1_reg); // [RL7]
          g1_next = g1_reg | wr_ones; // [RL1] [RL8]
        end
        `PWP_G2_CLR_OFS: begin
          wr_ones = w_data_reg & `PWP_G2_VALID;
          wr_double = |(wr_ones & ~g2_reg); // [RL7]
          g2_next = g2_reg & ~wr_ones; // [RL1] [RL2] [RL5]
        end
        `PWP_G2_SET_OFS: begin
          wr_ones = w_data_reg & `PWP_G2_VALID;
          wr_double = |(wr_ones & g2_reg); // [RL7]
          g2_next = g2_reg | wr_ones; // [RL1] [RL8] [RL5]
        end
        `PWP_IRQ_STAT_OFS: stat_clr = w_data_reg & `PWP_IRQ_VALID;
        `PWP_IRQ_MASK_OFS: mask_next = w_data_reg & `PWP_IRQ_VALID;
        default: wr_unmapped = 1'b1;
      endcase
    end
    bvalid_next = do_write || (bvalid_reg && !s_axi_bready);
    bresp_next = bresp_reg;
    if (do_write) begin
      bresp_next = (wr_double || wr_unmapped) ? `PWP_RESP_SLVERR : `PWP_RESP_OKAY; // [RL7]
    end
    // Check uses the state before any same-cycle register write
    chk_hit = periph_chk.group2 ? g2_reg[periph_chk.index] : g1_reg[periph_chk.index];
    chk_done_next = periph_chk.valid;
    chk_err_next = periph_chk.valid && chk_hit; // [RL6]
    stat_set[`PWP_EV_DOUBLE] = do_write && wr_double;
    stat_set[`PWP_EV_BLOCKED] = chk_err_next;
    // A new event beats a clear in the same cycle
    stat_next = (stat_reg & ~stat_clr) | stat_set;
    irq_next = |(stat_next & mask_next);
    rvalid_next = ar_fire || (rvalid_reg && !s_axi_rready);
    arready_next = !rvalid_next;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_fire) begin
      rresp_next = `PWP_RESP_OKAY;
      case (s_axi_araddr)
        `PWP_G1_CLR_OFS, `PWP_G1_SET_OFS: rdata_next = g1_reg; // [RL3] [RL4]
        `PWP_G2_CLR_OFS, `PWP_G2_SET_OFS: rdata_next = g2_reg; // [RL3] [RL5]
        `PWP_IRQ_STAT_OFS: rdata_next = stat_reg;
        `PWP_IRQ_MASK_OFS: rdata_next = mask_reg;
        default: begin
          rdata_next = 32'h0;
          rresp_next = `PWP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `PWP_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `PWP_RESP_OKAY;
      rdata_reg <= 32'h0;
      g1_reg <= `PWP_G1_RESET; // [RL4]
      g2_reg <= `PWP_G2_RESET;
      stat_reg <= 32'h0;
      mask_reg <= 32'h0;
      irq_reg <= 1'b0;
      chk_done_reg <= 1'b0;
      chk_err_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      g1_reg <= g1_next;
      g2_reg <= g2_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      chk_done_reg <= chk_done_next;
      chk_err_reg <= chk_err_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign group1_protect = g1_reg;
  assign group2_protect = g2_reg;
  assign irq = irq_reg;
  assign periph_chk_done = chk_done_reg;
  assign periph_chk_err = chk_err_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_zero_no_effect: assert property (do_write && wr_ones == 32'h0 |=> // [RL1]
    $stable(g1_reg) && $stable(g2_reg)) else $error("zero write changed protection");
  // Bit 1 is mapped in both groups, so each write is checked against its own group only
  a_clear_removes: assert property (do_write && (aw_addr_reg == `PWP_G1_CLR_OFS || // [RL2]
    aw_addr_reg == `PWP_G2_CLR_OFS) |=> (($past(aw_addr_reg[4]) ? g2_reg : g1_reg) &
    $past(wr_ones)) == 32'h0) else $error("clear write left protection on");
  a_read_state: assert property (ar_fire && s_axi_araddr == `PWP_G1_SET_OFS |=> // [RL3]
    s_axi_rvalid && s_axi_rdata == $past(g1_reg)) else $error("read value differs");
  a_group1_layout: assert property ((g1_reg & ~`PWP_G1_VALID) == // [RL4]
    (`PWP_G1_RESET & ~`PWP_G1_VALID)) else $error("group one stray bit");
  a_group2_layout: assert property ((g2_reg & ~`PWP_G2_VALID) == // [RL5]
    (`PWP_G2_RESET & ~`PWP_G2_VALID)) else $error("group two stray bit");
  a_blocked_error: assert property (periph_chk.valid && chk_hit |=> // [RL6]
    periph_chk_err && periph_chk_done && stat_reg[`PWP_EV_BLOCKED])
    else $error("protected write not refused");
  a_check_quiet: assert property (!periph_chk.valid |=> // [RL6]
    !periph_chk_done && !periph_chk_err) else $error("check answer without request");
  a_open_passes: assert property (periph_chk.valid && !chk_hit |=> // [RL6]
    periph_chk_done && !periph_chk_err) else $error("open write refused");
  a_double_error: assert property (do_write && wr_double |=> // [RL7]
    s_axi_bvalid && s_axi_bresp == `PWP_RESP_SLVERR && stat_reg[`PWP_EV_DOUBLE])
    else $error("double operation not flagged");
  a_set_applies: assert property (do_write && (aw_addr_reg == `PWP_G1_SET_OFS || // [RL8]
    aw_addr_reg == `PWP_G2_SET_OFS) |=> (($past(aw_addr_reg[4]) ? g2_reg : g1_reg) &
    $past(wr_ones)) == $past(wr_ones)) else $error("set write left peripheral open");
  a_stat_sticky: assert property (stat_reg[`PWP_EV_BLOCKED] &&
    !(do_write && aw_addr_reg == `PWP_IRQ_STAT_OFS) |=> stat_reg[`PWP_EV_BLOCKED])
    else $error("status bit lost without clear");
  c_write_done: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
  c_double_err: cover property (do_write && wr_double);
  c_blocked_irq: cover property (periph_chk_err ##[1:4] irq);
  c_clear_open: cover property (do_write && aw_addr_reg == `PWP_G2_CLR_OFS && !wr_double &&
    wr_ones != 32'h0);
  c_read_back: cover property (ar_fire ##1 s_axi_rvalid && s_axi_rready);
endmodule

// file: testbench/pwp_core_model.sv
// Core-side model: issues one peripheral write check per go pulse.
// Assumes go, grp and idx change just after rising edges of mclk.
`timescale 1ns/10ps
module pwp_core_model
  import pwp_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire logic grp,
  input wire logic [4:0] idx,
  output pwp_chk_s chk
);
  // Target lines show the inverse between writes, so a stale match cannot hide
  always @(posedge mclk) begin
    if (go) begin
      chk <= '{1'b1, grp, idx};
    end else begin
      chk <= '{1'b0, ~grp, ~idx};
    end
  end
endmodule

// file: testbench/peripheral_write_protect_bench.sv
// Self-checking bench: AXI4-Lite register tasks, core check model, random mix.
// Assumes pwp_top and the register map of pwp_defines.svh.
`timescale 1ns/10ps
`include "pwp_defines.svh"
module peripheral_write_protect_bench
  import pwp_pkg::*;
;
  logic mclk = 0, rst = 1, go = 0, grp = 0, irq;
  logic [4:0] idx = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, periph_chk_done, periph_chk_err, s_aw, s_w, s_b, s_ar, s_r;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, s_br, s_rr, rs;
  pwp_word_t s_axi_wdata = 0, s_axi_rdata, group1_protect, group2_protect;
  pwp_word_t s_rd, rd, g1, g2, st, mk, wm = 32'hffff_ffff;
  pwp_chk_s periph_chk;
  int miscompares = 0, total_checks = 0;
  localparam logic [5:0] OFS[7] = '{`PWP_G1_CLR_OFS, `PWP_G1_SET_OFS, `PWP_G2_CLR_OFS,
    `PWP_G2_SET_OFS, `PWP_IRQ_STAT_OFS, `PWP_IRQ_MASK_OFS, 6'h08};
  localparam int BITS[14] = '{6, 5, 3, 2, 1, 20, 19, 18, 17, 16, 8, 9, 10, 1};
  pwp_top i_dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .periph_chk, .periph_chk_done, .periph_chk_err, .group1_protect,
    .group2_protect, .irq);
  pwp_core_model i_core (.mclk, .go, .grp, .idx, .chk(periph_chk));
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Registered outputs are stable mid-cycle: this is what the next edge sees
  always @(negedge mclk) begin
    {s_aw, s_w, s_b, s_br, s_ar, s_r, s_rr} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
      s_axi_bresp, s_axi_arready, s_axi_rvalid, s_axi_rresp};
    s_rd = s_axi_rdata;
  end
  task cmp_w(input pwp_word_t g, input pwp_word_t e, input string m);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task cmp_r(input logic [1:0] g, input logic [1:0] e, input string m);
    cmp_w({30'h0, g}, {30'h0, e}, m);
  endtask
  // Ready lines drop after each handshake: each valid is dropped once its ready is seen high, then the task waits for bvalid
  task axi_wr(input logic [5:0] a, input pwp_word_t d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge mclk);
      if (s_aw) s_axi_awvalid <= 0;
      if (s_w) s_axi_wvalid <= 0;
    end while (!s_b);
    rs = s_br;
  endtask
  task axi_rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge mclk);
      if (s_ar) s_axi_arvalid <= 0;
    end while (!s_r);
    rd = s_rd;
    rs = s_rr;
  endtask
  function logic [1:0] mw(input logic [5:0] a, input pwp_word_t d);
    pwp_word_t v, p;
    mw = `PWP_RESP_OKAY;
    if (a == `PWP_IRQ_STAT_OFS) st &= ~d;
    else if (a == `PWP_IRQ_MASK_OFS) mk = d & `PWP_IRQ_VALID;
    else if (a[5] || a[3] || a[1:0] != 0) mw = `PWP_RESP_SLVERR;
    else begin
      p = a[4] ? g2 : g1;
      v = d & (a[4] ? `PWP_G2_VALID : `PWP_G1_VALID);
      if (|(v & (a[2] ? p : ~p))) begin
        mw = `PWP_RESP_SLVERR;
        st[`PWP_EV_DOUBLE] = 1;
      end
      p = a[2] ? p | v : p & ~v;
      g1 = a[4] ? g1 : p;
      g2 = a[4] ? p : g2;
    end
  endfunction
  function pwp_word_t mr(input logic [5:0] a);
    mr = a == `PWP_IRQ_STAT_OFS ? st : a == `PWP_IRQ_MASK_OFS ? mk : 32'h0;
    if (a inside {OFS[0], OFS[1]}) mr = g1;
    if (a inside {OFS[2], OFS[3]}) mr = g2;
  endfunction
  task op(input logic [5:0] a, input pwp_word_t d);
    logic [1:0] e;
    e = mw(a, d & wm);
    axi_wr(a, d);
    cmp_r(rs, e, "bresp");
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    cmp_w(group1_protect, g1, "group1");
    cmp_w(group2_protect, g2, "group2");
    cmp_r({1'b0, irq}, {1'b0, |(st & mk)}, "irq");
    @(posedge mclk);
  endtask
  task rc(input logic [5:0] a);
    axi_rd(a);
    cmp_w(rd, mr(a), "rdata");
    cmp_r(rs, a inside {OFS[0], OFS[1], OFS[2], OFS[3], OFS[4], OFS[5]} ? `PWP_RESP_OKAY :
      `PWP_RESP_SLVERR, "rresp");
  endtask
  task pc(input logic g, input logic [4:0] i);
    logic e;
    e = g ? g2[i] : g1[i];
    go <= 1;
    grp <= g;
    idx <= i;
    @(posedge mclk);
    go <= 0;
    @(posedge mclk);
    @(negedge mclk);
    cmp_r({periph_chk_done, periph_chk_err}, {1'b1, e}, "check");
    if (e) st[`PWP_EV_BLOCKED] = 1;
    @(posedge mclk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    miscompares++;
    $display("wrong value t=%0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    int i, j;
    logic [5:0] a;
    logic [3:0] sb;
    g1 = `PWP_G1_RESET;
    g2 = `PWP_G2_RESET;
    st = 0;
    mk = 0;
    i = $urandom(62125);
    repeat (6) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    foreach (OFS[k]) rc(OFS[k]);
    op(OFS[6], 32'hffffffff);
    op(`PWP_IRQ_STAT_OFS, 32'h3);
    $display("test reset and map done");
    op(`PWP_IRQ_MASK_OFS, 32'h3);
    foreach (BITS[k]) begin
      a = k > 4 ? `PWP_G2_CLR_OFS : `PWP_G1_CLR_OFS;
      op(a | 6'h04, 32'h1 << BITS[k]);
      pc(k > 4, 5'(BITS[k]));
      op(a | 6'h04, 32'h1 << BITS[k]);
      op(a, 32'h1 << BITS[k]);
      op(a, 32'h1 << BITS[k]);
      pc(k > 4, 5'(BITS[k]));
      op(a | 6'h04, 32'h0);
      op(a, 32'h0);
      rc(a);
      op(`PWP_IRQ_STAT_OFS, 32'h3);
    end
    $display("test per-peripheral done");
    for (i = 0; i < 60; i++) begin
      j = $urandom_range(13);
      // Lanes without a strobe must act as zero writes
      sb = 4'($urandom_range(15));
      s_axi_wstrb <= sb;
      wm = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
      if ($urandom_range(1)) op(OFS[$urandom_range(5)], $urandom);
      else pc(j > 4, 5'(BITS[j]));
      rc(OFS[$urandom_range(6)]);
    end
    $display("test random mix done");
    rst <= 1;
    repeat (3) @(posedge mclk);
    rst <= 0;
    g1 = `PWP_G1_RESET;
    g2 = `PWP_G2_RESET;
    st = 0;
    mk = 0;
    @(posedge mclk);
    foreach (OFS[k]) rc(OFS[k]);
    pc(1'b0, 5'(`PWP_BIT_DEBUG_UNIT));
    $display("test mid-run reset done");
    finish_test;
  end
endmodule
